// *** src/cpsc_pkg.sv ***
// package: constants and types for the cell protection state controller
package cpsc_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned SAMPLE_PERIOD_MS = 8;
	localparam int unsigned OV_DELAY_MS     = 1000;
	localparam int unsigned OC_DELAY_US     = 1000;
	localparam int unsigned SAMPLE_CYCLES   = (CLK_HZ / 1000) * SAMPLE_PERIOD_MS;
	localparam int unsigned OC_CYCLES       = (CLK_HZ / 1000000) * OC_DELAY_US;
	localparam int unsigned OV_SAMPLES      = (OV_DELAY_MS + SAMPLE_PERIOD_MS - 1) / SAMPLE_PERIOD_MS;
	localparam int unsigned UV_SAMPLES      = 2;

	// ****************************************
	// analog setpoints carried for reference
	// ****************************************
	localparam int unsigned OC_LIMIT_MA     = 3000;
	localparam int unsigned OC_RELEASE_MV   = 50;
	localparam int unsigned LINEAR_VDS_MV   = 100;

	// ****************************************
	// states
	// ****************************************
	typedef enum logic [1:0] {
		CPSC_NORMAL_STATE        = 2'b00,
		CPSC_OVERCHARGE_STATE    = 2'b01,
		CPSC_OVERCURRENT_STATE   = 2'b11,
		CPSC_OVERDISCHARGE_STATE = 2'b10
	} cpsc_state_t;

	// comparator results of one cell sample
	typedef struct packed {
		logic below_uv;
		logic above_ov;
		logic at_uv_release;
	} cpsc_sense_t;

	// pass switch command
	typedef struct packed {
		logic switch_full_on;
		logic linear_mode;
		logic gate_to_battery;
		logic block_charge;
		logic block_discharge;
	} cpsc_drive_t;

endpackage : cpsc_pkg

// *** src/cpsc_timer.sv ***
// module: saturating cycle timer with qualifying level
`timescale 1ns/100ps
`default_nettype none
module cpsc_timer #(
	parameter int unsigned COUNT = cpsc_pkg::OC_CYCLES,
	parameter int unsigned WIDTH = 16
) (
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic run_i,
	output logic      done_o
);
	logic [WIDTH-1:0] cnt;
	logic [WIDTH-1:0] next_cnt;
	logic             next_done;

	always_comb begin
		next_cnt  = cnt;
		next_done = 1'b0;
		if (!run_i) begin
			next_cnt = '0;
		end else if (cnt == WIDTH'(COUNT - 1)) begin
			next_done = 1'b1;
		end else begin
			next_cnt = cnt + WIDTH'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt    <= '0;
			done_o <= 1'b0;
		end else begin
			cnt    <= next_cnt;
			done_o <= next_done;
		end
	end
endmodule : cpsc_timer
`default_nettype wire

// *** src/cpsc_ctrl.sv ***
// module: state controller of a single cell protection device
// ****************************************
// How it works
// ****************************************
// How it works
// - compare cell against reference once every 8 ms; voltage state changes follow those samples
// - two consecutive undervoltage samples open the switch and enter shutdown
// - shutdown holds, detection only, until a charger appears; then charging allowed
// - overvoltage held 1 s blocks charge but still passes discharge
// - overcurrent declared only after above 3 A for over 1 ms
// - overcurrent turns switch fully off, overriding every other path
// - latched overcurrent pulls pack minus down; within 50 mV clears it
// - normal state drives switch fully on from charge pump gate drive
// - overvoltage uses linear 100 mV regulation; heavy load gates to battery
// - after charger detect keep linear mode until undervoltage release level
`timescale 1ns/100ps
`default_nettype none
module cpsc_ctrl #(
	parameter int unsigned SAMPLE_CYCLES = cpsc_pkg::SAMPLE_CYCLES,
	parameter int unsigned OC_CYCLES     = cpsc_pkg::OC_CYCLES,
	parameter int unsigned OV_SAMPLES    = cpsc_pkg::OV_SAMPLES
) (
	input  wire logic                  clk_i,
	input  wire logic                  rst_n_i,
	input  wire logic                  below_uv_i,
	input  wire logic                  above_ov_i,
	input  wire logic                  at_uv_release_i,
	input  wire logic                  over_current_i,
	input  wire logic                  pack_neg_near_i,
	input  wire logic                  charger_detect_i,
	input  wire logic                  heavy_load_i,
	output logic                       sample_enable_o,
	output cpsc_pkg::cpsc_drive_t      drive_o,
	output logic                       pack_neg_pulldown_o,
	output logic                       detect_only_o,
	output cpsc_pkg::cpsc_state_t      state_o
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [6:0] sync_a;
	logic [6:0] sync_b;
	logic [6:0] next_sync_a;

	always_comb begin
		// low three bits line up with the sense struct, below_uv on top
		next_sync_a = {heavy_load_i, charger_detect_i, pack_neg_near_i, over_current_i,
			below_uv_i, above_ov_i, at_uv_release_i};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sync_a <= 7'h00;
			sync_b <= 7'h00;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= sync_a;
		end
	end

	cpsc_pkg::cpsc_sense_t sense;
	logic                  oc_s;
	logic                  near_s;
	logic                  chg_s;
	logic                  heavy_s;

	assign sense   = cpsc_pkg::cpsc_sense_t'(sync_b[2:0]);
	assign oc_s    = sync_b[3];
	assign near_s  = sync_b[4];
	assign chg_s   = sync_b[5];
	assign heavy_s = sync_b[6];

	// ****************************************
	// sample tick
	// ****************************************
	localparam int unsigned SW = $clog2(SAMPLE_CYCLES);
	logic [SW-1:0] samp_cnt;
	logic [SW-1:0] next_samp_cnt;
	logic          tick;
	logic          next_tick;

	always_comb begin
		next_tick     = 1'b0;
		next_samp_cnt = samp_cnt + SW'(1);
		if (samp_cnt == SW'(SAMPLE_CYCLES - 1)) begin
			next_samp_cnt = '0;
			next_tick     = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			samp_cnt <= '0;
			tick     <= 1'b0;
		end else begin
			samp_cnt <= next_samp_cnt;
			tick     <= next_tick;
		end
	end

	// ****************************************
	// overcurrent qualification
	// ****************************************
	logic oc_fault;

	cpsc_timer #(
		.COUNT (OC_CYCLES + 1),
		.WIDTH ($clog2(OC_CYCLES + 2))
	) u_oc_timer (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.run_i   (oc_s),
		.done_o  (oc_fault)
	);

	// ****************************************
	// qualification helpers
	// ****************************************
	// saturating count of consecutive qualifying samples; a miss starts over
	function automatic int unsigned qual_step(
		input int unsigned cnt,
		input logic        hit,
		input int unsigned limit
	);
		int unsigned step;
		step = 0;
		if (hit) begin
			step = (cnt == limit) ? cnt : cnt + 1;
		end
		return step;
	endfunction : qual_step

	// ****************************************
	// drive helpers
	// ****************************************
	// linear regulation drive; heavy load takes the gate to the cell voltage
	function automatic cpsc_pkg::cpsc_drive_t linear_drive(input logic heavy);
		cpsc_pkg::cpsc_drive_t drv;
		drv                 = '0;
		drv.linear_mode     = 1'b1;
		drv.gate_to_battery = heavy;
		return drv;
	endfunction : linear_drive

	// ****************************************
	// sample qualification
	// ****************************************
	localparam int unsigned OW = $clog2(OV_SAMPLES + 1);
	logic [1:0]    uv_cnt;
	logic [1:0]    next_uv_cnt;
	logic [1:0]    uv_step;
	logic [OW-1:0] ov_cnt;
	logic [OW-1:0] next_ov_cnt;
	logic [OW-1:0] ov_step;
	logic          leaving;

	// counts after this cycle's sample, before any state change
	assign uv_step = tick ? 2'(qual_step(32'(uv_cnt), sense.below_uv, cpsc_pkg::UV_SAMPLES)) : uv_cnt;
	assign ov_step = tick ? OW'(qual_step(32'(ov_cnt), sense.above_ov, OV_SAMPLES)) : ov_cnt;

	// a state change starts both qualifications afresh
	always_comb begin
		next_uv_cnt = uv_step;
		next_ov_cnt = ov_step;
		if (leaving) begin
			next_uv_cnt = 2'h0;
			next_ov_cnt = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			uv_cnt <= 2'h0;
			ov_cnt <= '0;
		end else begin
			uv_cnt <= next_uv_cnt;
			ov_cnt <= next_ov_cnt;
		end
	end

	// ****************************************
	// state machine
	// ****************************************
	cpsc_pkg::cpsc_state_t state;
	cpsc_pkg::cpsc_state_t next_state;
	logic                  charging;
	logic                  next_charging;

	always_comb begin
		next_state    = state;
		next_charging = charging;
		unique case (state)
			cpsc_pkg::CPSC_NORMAL_STATE: begin
				next_charging = 1'b0;
				if (oc_fault) begin
					next_state = cpsc_pkg::CPSC_OVERCURRENT_STATE;
				end else if (uv_step == 2'(cpsc_pkg::UV_SAMPLES)) begin
					next_state = cpsc_pkg::CPSC_OVERDISCHARGE_STATE;
				end else if (ov_step == OW'(OV_SAMPLES)) begin
					next_state = cpsc_pkg::CPSC_OVERCHARGE_STATE;
				end
			end
			cpsc_pkg::CPSC_OVERCHARGE_STATE: begin
				if (oc_fault) begin
					next_state = cpsc_pkg::CPSC_OVERCURRENT_STATE;
				end else if (tick && !sense.above_ov) begin
					next_state = cpsc_pkg::CPSC_NORMAL_STATE;
				end
			end
			cpsc_pkg::CPSC_OVERCURRENT_STATE: begin
				if (near_s) begin
					next_state = cpsc_pkg::CPSC_NORMAL_STATE;
				end
			end
			cpsc_pkg::CPSC_OVERDISCHARGE_STATE: begin
				if (oc_fault) begin
					next_state = cpsc_pkg::CPSC_OVERCURRENT_STATE;
				end else if (!charging) begin
					if (chg_s) begin
						next_charging = 1'b1;
					end
				end else if (tick && sense.at_uv_release) begin
					next_state    = cpsc_pkg::CPSC_NORMAL_STATE;
					next_charging = 1'b0;
				end
			end
		endcase
		leaving = (next_state != state);
	end

	// ****************************************
	// state registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state    <= cpsc_pkg::CPSC_NORMAL_STATE;
			charging <= 1'b0;
		end else begin
			state    <= next_state;
			charging <= next_charging;
		end
	end

	// ****************************************
	// outputs
	// ****************************************
	cpsc_pkg::cpsc_drive_t next_drive;
	logic                  next_pulldown;
	logic                  next_detect_only;

	always_comb begin
		next_drive       = '0;
		next_pulldown    = 1'b0;
		next_detect_only = 1'b0;
		unique case (next_state)
			cpsc_pkg::CPSC_NORMAL_STATE: begin
				next_drive.switch_full_on = 1'b1;
			end
			cpsc_pkg::CPSC_OVERCHARGE_STATE: begin
				next_drive              = linear_drive(heavy_s);
				next_drive.block_charge = 1'b1;
			end
			cpsc_pkg::CPSC_OVERCURRENT_STATE: begin
				next_drive.block_charge    = 1'b1;
				next_drive.block_discharge = 1'b1;
				next_pulldown              = 1'b1;
			end
			cpsc_pkg::CPSC_OVERDISCHARGE_STATE: begin
				if (next_charging) begin
					next_drive = linear_drive(heavy_s);
				end else begin
					next_drive.block_charge = 1'b1;
					next_detect_only        = 1'b1;
				end
				next_drive.block_discharge = 1'b1;
			end
		endcase
	end

	// ****************************************
	// output registers
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			drive_o             <= '0;
			pack_neg_pulldown_o <= 1'b0;
			detect_only_o       <= 1'b0;
			state_o             <= cpsc_pkg::CPSC_NORMAL_STATE;
			sample_enable_o     <= 1'b0;
		end else begin
			drive_o             <= next_drive;
			pack_neg_pulldown_o <= next_pulldown;
			detect_only_o       <= next_detect_only;
			state_o             <= next_state;
			sample_enable_o     <= next_tick;
		end
	end
endmodule : cpsc_ctrl
`default_nettype wire

// *** sim/cpsc_ctrl_properties.sv ***
// checker: port properties of the cell protection controller
`timescale 1ns/100ps
`default_nettype none
module cpsc_ctrl_properties (
	input wire logic                  clk_i,
	input wire logic                  rst_n_i,
	input wire logic                  over_current_i,
	input wire logic                  pack_neg_near_i,
	input wire logic                  sample_enable_o,
	input wire cpsc_pkg::cpsc_drive_t drive_o,
	input wire logic                  pack_neg_pulldown_o,
	input wire logic                  detect_only_o,
	input wire cpsc_pkg::cpsc_state_t state_o
);
	// ****************************************
	// properties
	// ****************************************
	localparam cpsc_pkg::cpsc_state_t NS = cpsc_pkg::CPSC_NORMAL_STATE;
	localparam cpsc_pkg::cpsc_state_t OCHG = cpsc_pkg::CPSC_OVERCHARGE_STATE;
	localparam cpsc_pkg::cpsc_state_t OC = cpsc_pkg::CPSC_OVERCURRENT_STATE;
	localparam cpsc_pkg::cpsc_state_t OD = cpsc_pkg::CPSC_OVERDISCHARGE_STATE;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	a_sample_pulse_gap: assert property (sample_enable_o |=> !sample_enable_o [*8])
		else $error("sample pulses too close");
	a_shutdown_switch_off: assert property ((state_o == OD) [*2] |-> !drive_o.switch_full_on
		&& drive_o.block_discharge)
		else $error("shutdown leaves discharge open");
	a_detect_only_od: assert property (detect_only_o |-> state_o == OD && !drive_o.linear_mode)
		else $error("detect only outside shutdown");
	a_overcharge_drive: assert property ((state_o == OCHG) [*2] |-> drive_o.linear_mode && drive_o.block_charge
		&& !drive_o.block_discharge)
		else $error("overcharge drive wrong");
	a_oc_qualify_time: assert property ($rose(state_o == OC) |-> $past(over_current_i, 4) && $past(over_current_i, 10)
		&& $past(over_current_i, 12))
		else $error("overcurrent declared too early");
	a_oc_drive_off: assert property ((state_o == OC) [*2] |-> !drive_o.switch_full_on && pack_neg_pulldown_o)
		else $error("overcurrent drive wrong");
	a_oc_latch_hold: assert property ((state_o == OC && !pack_neg_near_i) [*4] |=> state_o == OC)
		else $error("overcurrent left without release");
	a_oc_release_time: assert property ((state_o == OC && pack_neg_near_i) [*3] |=> state_o == NS)
		else $error("overcurrent release late");
	a_normal_full_on: assert property ((state_o == NS) [*3] |-> drive_o == 5'h10)
		else $error("normal drive not full on");
endmodule : cpsc_ctrl_properties
`default_nettype wire

// *** sim/cpsc_cell_model.sv ***
// model: cell, pack load and charger facing the controller
`timescale 1ns/100ps
`default_nettype none
module cpsc_cell_model (
	input  wire logic [1:0]       level_i,
	input  wire logic             load_i,
	input  wire logic             surge_i,
	input  wire logic             heavy_i,
	input  wire logic             charger_i,
	input  wire logic             pulldown_i,
	output cpsc_pkg::cpsc_sense_t sense_o,
	output logic                  over_current_o,
	output logic                  pack_neg_near_o,
	output logic                  charger_detect_o,
	output logic                  heavy_load_o
);
	// ****************************************
	// cell levels: 0 low, 1 mid, 2 good, 3 high
	// ****************************************
	assign sense_o.below_uv      = (level_i == 2'h0);
	assign sense_o.above_ov      = (level_i == 2'h3);
	assign sense_o.at_uv_release = level_i[1];
	assign over_current_o        = load_i & surge_i;
	assign heavy_load_o          = load_i & heavy_i;
	assign charger_detect_o      = charger_i;
	assign pack_neg_near_o       = !load_i & pulldown_i;
endmodule : cpsc_cell_model
`default_nettype wire

// *** sim/testbench.sv ***
// testbench: directed scenarios for the cell protection controller
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic                  clk_i = 1'b0;
	logic                  rst_n_i = 1'b0;
	logic [1:0]            level = 2'h2;
	logic                  load = 1'b1;
	logic                  surge = 1'b0;
	logic                  heavy = 1'b0;
	logic                  chg = 1'b0;
	cpsc_pkg::cpsc_sense_t sense;
	logic                  oc, near, det, hvy, smp, pd, dto;
	cpsc_pkg::cpsc_drive_t drv;
	cpsc_pkg::cpsc_state_t st;
	int                    miscompares = 0;
	int                    check_count = 0;
	always #12.5 clk_i = ~clk_i;
	cpsc_cell_model i_cpsc_cell_model (.level_i(level), .load_i(load), .surge_i(surge), .heavy_i(heavy),
		.charger_i(chg), .pulldown_i(pd), .sense_o(sense), .over_current_o(oc), .pack_neg_near_o(near),
		.charger_detect_o(det), .heavy_load_o(hvy));
	cpsc_ctrl #(.SAMPLE_CYCLES(16), .OC_CYCLES(8), .OV_SAMPLES(4)) i_cpsc_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.below_uv_i(sense.below_uv), .above_ov_i(sense.above_ov), .at_uv_release_i(sense.at_uv_release),
		.over_current_i(oc), .pack_neg_near_i(near), .charger_detect_i(det), .heavy_load_i(hvy),
		.sample_enable_o(smp), .drive_o(drv), .pack_neg_pulldown_o(pd), .detect_only_o(dto), .state_o(st));
	// ****************************************
	// helpers
	// ****************************************
	task automatic check(input logic [4:0] seen, input logic [4:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i iff smp === 1'b1);
		#1;
	endtask : tick
	task automatic results;
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : results
	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rst_n_i = 1'b0;
		cyc(8);
		rst_n_i = 1'b1;
		cyc(3);
		check({3'h0, st}, 5'h00);
		check(drv, 5'h10);
	endtask : t_reset
	task automatic t_sample;
		int n;
		tick(1);
		for (n = 0; n < 40 && smp !== 1'b1; n++) cyc(1);
		check(n[4:0], 5'h0f);
	endtask : t_sample
	task automatic t_uv;
		tick(1);
		level = 2'h0;
		cyc(16);
		level = 2'h2;
		tick(3);
		check({3'h0, st}, 5'h00);
		level = 2'h0;
		cyc(32);
		level = 2'h1;
		cyc(4);
		check({3'h0, st}, 5'h02);
		check({3'h0, dto, drv.switch_full_on}, 5'h02);
		tick(2);
		check({3'h0, dto, drv.switch_full_on}, 5'h02);
		chg = 1'b1;
		cyc(5);
		check({dto, drv.linear_mode, drv.block_discharge, drv.block_charge, drv.switch_full_on}, 5'h0c);
		tick(3);
		check({3'h0, st}, 5'h02);
		level = 2'h2;
		tick(3);
		check({3'h0, st}, 5'h00);
		check(drv, 5'h10);
		chg = 1'b0;
	endtask : t_uv
	task automatic t_ov;
		repeat (2) begin
			tick(1);
			level = 2'h3;
			cyc(48);
			level = 2'h2;
		end
		tick(2);
		check({3'h0, st}, 5'h00);
		level = 2'h3;
		tick(6);
		check({3'h0, st}, 5'h01);
		check(drv, 5'h0a);
		heavy = 1'b1;
		cyc(5);
		check(drv, 5'h0e);
		heavy = 1'b0;
		level = 2'h2;
		tick(2);
		check({3'h0, st}, 5'h00);
	endtask : t_ov
	task automatic t_oc;
		surge = 1'b1;
		cyc(5);
		surge = 1'b0;
		cyc(20);
		check({3'h0, st}, 5'h00);
		surge = 1'b1;
		cyc(20);
		check({pd, st, drv.switch_full_on, drv.block_discharge}, 5'h1d);
		surge = 1'b0;
		level = 2'h0;
		tick(3);
		check({3'h0, st}, 5'h03);
		level = 2'h2;
		load = 1'b0;
		cyc(6);
		check({3'h0, st}, 5'h00);
		check(drv, 5'h10);
		load = 1'b1;
	endtask : t_oc
	initial begin
		#200000;
		miscompares++;
		results();
	end
	initial begin
		t_reset();
		t_sample();
		t_uv();
		t_ov();
		t_oc();
		results();
	end
endmodule : testbench
bind cpsc_ctrl cpsc_ctrl_properties i_cpsc_ctrl_properties (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.over_current_i(over_current_i), .pack_neg_near_i(pack_neg_near_i), .sample_enable_o(sample_enable_o),
	.drive_o(drive_o), .pack_neg_pulldown_o(pack_neg_pulldown_o), .detect_only_o(detect_only_o), .state_o(state_o));
`default_nettype wire
